/* File: design/ccc_core.sv */
// crosspoint command interpreter: parses brace commands, keeps state, replies
// assumes a byte stream with valid/ready handshakes on both sides
`timescale 1ns/1ps
module ccc_core #(
	parameter int BATCH_CYC = ccc_pkg::BATCH_CYC_DEF
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// command characters
	input wire logic rx_valid_in,
	input wire logic [7:0] rx_data_in,
	output logic rx_ready_out,
	// reply characters
	output logic tx_valid_out,
	output logic [7:0] tx_data_out,
	input wire logic tx_ready_in,
	// crosspoint state
	output logic [ccc_pkg::NUM_VID*ccc_pkg::IN_W-1:0] vid_sel_out,
	output logic [ccc_pkg::NUM_VID-1:0] vid_en_out,
	output logic [ccc_pkg::IN_W-1:0] aud_sel_out,
	output logic aud_en_out,
	output logic [ccc_pkg::NUM_OUT-1:0] lock_out
);
	// ****************************************
	// state and helpers
	// ****************************************
	logic [ccc_pkg::IN_W-1:0] conn_q [ccc_pkg::NUM_OUT];
	logic [ccc_pkg::NUM_OUT-1:0] en_q;
	logic [ccc_pkg::NUM_OUT-1:0] lock_q;
	logic [ccc_pkg::IN_W-1:0] pend_sel_q [ccc_pkg::NUM_OUT];
	logic [ccc_pkg::NUM_OUT-1:0] pend_mask_q;
	logic [ccc_pkg::TMR_W-1:0] timer_q;
	ccc_pkg::ccc_pst_t pst_q;
	ccc_pkg::ccc_op_t pop_q;
	ccc_pkg::ccc_op_t dec_op;
	ccc_pkg::ccc_op_t ex_op_q;
	logic [2:0] pos_q;
	logic [ccc_pkg::NUM_W-1:0] na_q;
	logic [ccc_pkg::NUM_W-1:0] nb_q;
	logic [1:0] nd_q;
	logic at_q;
	logic [ccc_pkg::NUM_W-1:0] ex_a_q;
	logic [ccc_pkg::NUM_W-1:0] ex_b_q;
	logic ex_go_q;
	logic bld_go_q;
	logic rx_ready_q;
	logic tx_valid_q;
	logic [7:0] tx_data_q;
	logic [7:0] resp_q [ccc_pkg::RESP_MAX];
	logic [7:0] resp_d [ccc_pkg::RESP_MAX];
	logic [ccc_pkg::LEN_W-1:0] len_d;
	logic [ccc_pkg::LEN_W-1:0] tx_len_q;
	logic [ccc_pkg::LEN_W-1:0] tx_idx_q;
	logic rx_take;
	logic [7:0] up;
	logic is_dig;
	logic [ccc_pkg::NUM_W-1:0] dig;
	logic [ccc_pkg::NUM_W-1:0] acc;
	logic [7:0] word_ch;
	logic end_cmd;
	logic junk;
	logic [ccc_pkg::OUT_IW-1:0] oidx;
	logic sw_one;
	logic sw_all;
	logic batchable;
	logic brk;
	logic pend_act;
	logic expire;
	logic flush;

	function automatic logic [15:0] dig2(input logic [ccc_pkg::NUM_W-1:0] v);
		dig2 = {8'(ccc_pkg::CH_ZERO + 8'(v / ccc_pkg::DEC_BASE)), 8'(ccc_pkg::CH_ZERO + 8'(v % ccc_pkg::DEC_BASE))};
	endfunction : dig2

	assign rx_take = rx_valid_in && rx_ready_q;
	assign up = rx_data_in & ccc_pkg::CASE_MASK;
	assign is_dig = (rx_data_in >= ccc_pkg::CH_ZERO) && (rx_data_in <= ccc_pkg::CH_NINE);
	assign dig = ccc_pkg::NUM_W'(rx_data_in - ccc_pkg::CH_ZERO);
	assign acc = ccc_pkg::NUM_W'((at_q || pop_q != ccc_pkg::OP_SW ? nb_q : na_q) * ccc_pkg::DEC_BASE + dig);
	assign word_ch = (pop_q == ccc_pkg::OP_SIZE) ? ccc_pkg::WORD_SIZE[8*(6-pos_q) +: 8]
		: ccc_pkg::WORD_VIEW[8*(1-pos_q[0]) +: 8];
	assign end_cmd = rx_take && pst_q == ccc_pkg::P_BODY && rx_data_in == ccc_pkg::CH_RBRACE;
	assign junk = rx_take && pst_q == ccc_pkg::P_IDLE && rx_data_in != ccc_pkg::CH_LBRACE;
	assign oidx = ccc_pkg::OUT_IW'(ex_b_q - 7'h01);
	assign sw_one = ex_go_q && ex_op_q == ccc_pkg::OP_SW && ex_b_q != 7'h00;
	assign sw_all = ex_go_q && ex_op_q == ccc_pkg::OP_SW && ex_b_q == 7'h00;
	assign batchable = sw_one && !lock_q[oidx];
	assign brk = junk || (ex_go_q && !batchable);
	assign pend_act = |pend_mask_q;
	assign expire = pend_act && timer_q == ccc_pkg::TMR_W'(BATCH_CYC - 1) && !batchable;
	assign flush = pend_act && (brk || expire);

	// ****************************************
	// character parser
	// ****************************************
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			pst_q <= ccc_pkg::P_IDLE;
			pop_q <= ccc_pkg::OP_NONE;
			pos_q <= 3'h0;
			na_q <= 7'h00;
			nb_q <= 7'h00;
			nd_q <= 2'h0;
			at_q <= 1'b0;
		end else if (rx_take) begin
			if (pst_q == ccc_pkg::P_IDLE) begin
				if (rx_data_in == ccc_pkg::CH_LBRACE) begin
					pst_q <= ccc_pkg::P_BODY;
					pop_q <= ccc_pkg::OP_NONE;
					pos_q <= 3'h0;
					na_q <= 7'h00;
					nb_q <= 7'h00;
					nd_q <= 2'h0;
					at_q <= 1'b0;
				end
			end else if (rx_data_in == ccc_pkg::CH_RBRACE) begin
				pst_q <= ccc_pkg::P_IDLE;
			end else begin
				case (pop_q)
					ccc_pkg::OP_NONE: begin
						pos_q <= 3'h1;
						nd_q <= 2'h0;
						if (rx_data_in == ccc_pkg::CH_HASH) begin
							pop_q <= ccc_pkg::OP_MUTE;
						end else if (rx_data_in == ccc_pkg::CH_PLUS) begin
							pop_q <= ccc_pkg::OP_UNMUTE;
						end else if (is_dig) begin
							pop_q <= ccc_pkg::OP_SW;
							na_q <= dig;
							nd_q <= 2'h1;
						end else if (up == ccc_pkg::CH_V) begin
							pop_q <= ccc_pkg::OP_VIEW;
						end else if (up == ccc_pkg::CH_G) begin
							pop_q <= ccc_pkg::OP_SIZE;
						end else begin
							pop_q <= ccc_pkg::OP_ERR;
						end
					end
					ccc_pkg::OP_SW, ccc_pkg::OP_MUTE, ccc_pkg::OP_UNMUTE, ccc_pkg::OP_LOCK, ccc_pkg::OP_UNLOCK: begin
						if (is_dig && nd_q != 2'h2) begin
							nd_q <= nd_q + 2'h1;
							if (pop_q == ccc_pkg::OP_SW && !at_q) begin
								na_q <= acc;
							end else begin
								nb_q <= acc;
							end
						end else if (pop_q == ccc_pkg::OP_SW && rx_data_in == ccc_pkg::CH_AT && !at_q) begin
							at_q <= 1'b1;
							nd_q <= 2'h0;
						end else if (pop_q == ccc_pkg::OP_MUTE && rx_data_in == ccc_pkg::CH_GT && nd_q == 2'h0) begin
							pop_q <= ccc_pkg::OP_LOCK;
						end else if (pop_q == ccc_pkg::OP_UNMUTE && rx_data_in == ccc_pkg::CH_LT && nd_q == 2'h0) begin
							pop_q <= ccc_pkg::OP_UNLOCK;
						end else begin
							pop_q <= ccc_pkg::OP_ERR;
						end
					end
					ccc_pkg::OP_VIEW, ccc_pkg::OP_SIZE: begin
						if (up == word_ch && pos_q != ccc_pkg::LEN_SIZE) begin
							pos_q <= pos_q + 3'h1;
						end else begin
							pop_q <= ccc_pkg::OP_ERR;
						end
					end
					default: begin
						pop_q <= ccc_pkg::OP_ERR;
					end
				endcase
			end
		end
	end

	// ****************************************
	// command decode at closing brace
	// ****************************************
	always_comb begin
		dec_op = ccc_pkg::OP_ERR;
		case (pop_q)
			ccc_pkg::OP_SW: begin
				if (at_q && nd_q != 2'h0 && na_q >= 7'h01 && na_q <= ccc_pkg::NUM_W'(ccc_pkg::NUM_IN)
					&& nb_q <= ccc_pkg::NUM_W'(ccc_pkg::NUM_OUT)) begin
					dec_op = ccc_pkg::OP_SW;
				end
			end
			ccc_pkg::OP_MUTE, ccc_pkg::OP_UNMUTE, ccc_pkg::OP_LOCK, ccc_pkg::OP_UNLOCK: begin
				if (nd_q != 2'h0 && nb_q >= 7'h01 && nb_q <= ccc_pkg::NUM_W'(ccc_pkg::NUM_OUT)) begin
					dec_op = pop_q;
				end
			end
			ccc_pkg::OP_VIEW: begin
				if (pos_q == ccc_pkg::LEN_VIEW) begin
					dec_op = ccc_pkg::OP_VIEW;
				end
			end
			ccc_pkg::OP_SIZE: begin
				if (pos_q == ccc_pkg::LEN_SIZE) begin
					dec_op = ccc_pkg::OP_SIZE;
				end
			end
			default: begin
				dec_op = ccc_pkg::OP_ERR;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			ex_go_q <= 1'b0;
			bld_go_q <= 1'b0;
			ex_op_q <= ccc_pkg::OP_NONE;
			ex_a_q <= 7'h00;
			ex_b_q <= 7'h00;
		end else begin
			ex_go_q <= end_cmd;
			bld_go_q <= ex_go_q;
			if (end_cmd) begin
				ex_op_q <= dec_op;
				ex_a_q <= na_q;
				ex_b_q <= nb_q;
			end
		end
	end

	// ****************************************
	// batch collection, timed on arrival
	// ****************************************
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			pend_mask_q <= '0;
			timer_q <= '0;
		end else begin
			if (batchable) begin
				pend_mask_q <= (flush ? '0 : pend_mask_q) | (ccc_pkg::NUM_OUT'(1) << oidx);
				timer_q <= '0;
			end else if (flush) begin
				pend_mask_q <= '0;
				timer_q <= '0;
			end else if (pend_act) begin
				timer_q <= timer_q + ccc_pkg::TMR_W'(1);
			end
		end
	end

	// ****************************************
	// crosspoint, mute and lock state
	// ****************************************
	for (genvar o = 0; o < ccc_pkg::NUM_OUT; o++) begin : g_out
		always_ff @(posedge clk_sys_in) begin
			if (!rst_n_in) begin
				pend_sel_q[o] <= ccc_pkg::RST_CONN;
			end else if (batchable && oidx == ccc_pkg::OUT_IW'(o)) begin
				pend_sel_q[o] <= ccc_pkg::IN_W'(ex_a_q);
			end
		end
		always_ff @(posedge clk_sys_in) begin
			if (!rst_n_in) begin
				conn_q[o] <= ccc_pkg::RST_CONN;
			end else if (sw_all && !lock_q[o]) begin
				conn_q[o] <= ccc_pkg::IN_W'(ex_a_q);
			end else if (flush && pend_mask_q[o]) begin
				conn_q[o] <= pend_sel_q[o];
			end
		end
		always_ff @(posedge clk_sys_in) begin
			if (!rst_n_in) begin
				en_q[o] <= 1'b1;
				lock_q[o] <= 1'b0;
			end else if (ex_go_q && oidx == ccc_pkg::OUT_IW'(o)) begin
				if (ex_op_q == ccc_pkg::OP_MUTE && !lock_q[o]) begin
					en_q[o] <= 1'b0;
				end
				if (ex_op_q == ccc_pkg::OP_UNMUTE && !lock_q[o]) begin
					en_q[o] <= 1'b1;
				end
				if (ex_op_q == ccc_pkg::OP_LOCK) begin
					lock_q[o] <= 1'b1;
				end
				if (ex_op_q == ccc_pkg::OP_UNLOCK) begin
					lock_q[o] <= 1'b0;
				end
			end
		end
	end
	for (genvar v = 0; v < ccc_pkg::NUM_VID; v++) begin : g_vid
		assign vid_sel_out[v*ccc_pkg::IN_W +: ccc_pkg::IN_W] = conn_q[v];
	end
	assign vid_en_out = en_q[ccc_pkg::NUM_VID-1:0];
	assign aud_sel_out = conn_q[ccc_pkg::NUM_OUT-1];
	assign aud_en_out = en_q[ccc_pkg::NUM_OUT-1];
	assign lock_out = lock_q;

	// ****************************************
	// reply builder
	// ****************************************
	always_comb begin
		int idx;
		logic [15:0] d2;
		idx = 0;
		d2 = 16'h0000;
		for (int k = 0; k < ccc_pkg::RESP_MAX; k++) begin
			resp_d[k] = ccc_pkg::CH_SP;
		end
		resp_d[0] = ccc_pkg::CH_LPAR;
		case (ex_op_q)
			ccc_pkg::OP_SW: begin
				if (ex_b_q != 7'h00) begin
					d2 = dig2(ex_b_q);
					resp_d[1] = ccc_pkg::CH_O;
					{resp_d[2], resp_d[3]} = d2;
					resp_d[5] = ccc_pkg::CH_I;
					{resp_d[6], resp_d[7]} = dig2(ex_a_q);
				end else begin
					resp_d[1] = ccc_pkg::CH_I;
					{resp_d[2], resp_d[3]} = dig2(ex_a_q);
					resp_d[5] = ccc_pkg::CH_A;
					resp_d[6] = ccc_pkg::CH_L;
					resp_d[7] = ccc_pkg::CH_L;
				end
				idx = 8;
			end
			ccc_pkg::OP_MUTE, ccc_pkg::OP_UNMUTE, ccc_pkg::OP_LOCK, ccc_pkg::OP_UNLOCK: begin
				resp_d[1] = (ex_op_q == ccc_pkg::OP_MUTE || ex_op_q == ccc_pkg::OP_LOCK) ? ccc_pkg::CH_ONE
					: ccc_pkg::CH_ZERO;
				resp_d[2] = (ex_op_q == ccc_pkg::OP_MUTE || ex_op_q == ccc_pkg::OP_UNMUTE) ? ccc_pkg::CH_M
					: ccc_pkg::CH_L;
				resp_d[3] = (ex_op_q == ccc_pkg::OP_MUTE || ex_op_q == ccc_pkg::OP_UNMUTE) ? ccc_pkg::CH_T
					: ccc_pkg::CH_O;
				{resp_d[4], resp_d[5]} = dig2(ex_b_q);
				idx = 6;
			end
			ccc_pkg::OP_VIEW: begin
				resp_d[1] = ccc_pkg::CH_A;
				resp_d[2] = ccc_pkg::CH_L;
				resp_d[3] = ccc_pkg::CH_L;
				idx = 4;
				for (int o = 0; o < ccc_pkg::NUM_OUT; o++) begin
					idx = idx + 1;
					if (lock_q[o] || !en_q[o]) begin
						resp_d[idx] = (lock_q[o] && !en_q[o]) ? ccc_pkg::CH_U
							: (lock_q[o] ? ccc_pkg::CH_L : ccc_pkg::CH_M);
						idx = idx + 1;
					end
					{resp_d[idx], resp_d[idx+1]} = dig2(ccc_pkg::NUM_W'(conn_q[o]));
					idx = idx + 2;
				end
			end
			ccc_pkg::OP_SIZE: begin
				resp_d[1] = ccc_pkg::CH_S;
				resp_d[2] = ccc_pkg::CH_I;
				resp_d[3] = ccc_pkg::CH_Z;
				resp_d[4] = ccc_pkg::CH_E;
				resp_d[5] = ccc_pkg::CH_EQ;
				resp_d[6] = 8'(ccc_pkg::CH_ZERO + 8'(ccc_pkg::NUM_IN));
				resp_d[7] = ccc_pkg::CH_XL;
				resp_d[8] = 8'(ccc_pkg::CH_ZERO + 8'(ccc_pkg::NUM_OUT));
				idx = 9;
			end
			default: begin
				resp_d[1] = ccc_pkg::CH_E;
				resp_d[2] = ccc_pkg::CH_R;
				resp_d[3] = ccc_pkg::CH_R;
				idx = 4;
			end
		endcase
		resp_d[idx] = ccc_pkg::CH_RPAR;
		resp_d[idx+1] = ccc_pkg::CH_CR;
		resp_d[idx+2] = ccc_pkg::CH_LF;
		len_d = ccc_pkg::LEN_W'(idx + 3);
	end

	// ****************************************
	// reply sender, one line per command
	// ****************************************
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			rx_ready_q <= 1'b1;
			tx_valid_q <= 1'b0;
			tx_data_q <= 8'h00;
			tx_len_q <= '0;
			tx_idx_q <= '0;
		end else if (end_cmd) begin
			rx_ready_q <= 1'b0;
		end else if (bld_go_q) begin
			tx_valid_q <= 1'b1;
			tx_data_q <= resp_d[0];
			tx_len_q <= len_d;
			tx_idx_q <= ccc_pkg::LEN_W'(1);
		end else if (tx_valid_q && tx_ready_in) begin
			if (tx_idx_q == tx_len_q) begin
				tx_valid_q <= 1'b0;
				rx_ready_q <= 1'b1;
			end else begin
				tx_data_q <= resp_q[tx_idx_q];
				tx_idx_q <= tx_idx_q + ccc_pkg::LEN_W'(1);
			end
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (bld_go_q) begin
			resp_q <= resp_d;
		end
	end
	assign rx_ready_out = rx_ready_q;
	assign tx_valid_out = tx_valid_q;
	assign tx_data_out = tx_data_q;

	// ****************************************
	// checks
	// ****************************************
	property p_sw_ack;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		bld_go_q && ex_op_q == ccc_pkg::OP_SW && ex_b_q != 7'h00 |-> resp_d[1] == ccc_pkg::CH_O
			&& {resp_d[2], resp_d[3]} == dig2(ex_b_q) && {resp_d[6], resp_d[7]} == dig2(ex_a_q);
	endproperty
	a_sw_ack: assert property (p_sw_ack) else $error("switch ack fields wrong");
	property p_sw_all;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		sw_all && lock_q == '0 |=> conn_q[0] == ccc_pkg::IN_W'($past(ex_a_q))
			&& conn_q[ccc_pkg::NUM_OUT-1] == ccc_pkg::IN_W'($past(ex_a_q));
	endproperty
	a_sw_all: assert property (p_sw_all) else $error("switch to all not applied");
	property p_sw_len;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		bld_go_q && ex_op_q == ccc_pkg::OP_SW |-> len_d == ccc_pkg::LEN_SWITCH;
	endproperty
	a_sw_len: assert property (p_sw_len) else $error("switch ack length wrong");
	property p_mute;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		ex_go_q && ex_op_q == ccc_pkg::OP_MUTE && !lock_q[oidx] |=> !en_q[$past(oidx)] ##1 resp_d[1] == ccc_pkg::CH_ONE
			&& resp_d[2] == ccc_pkg::CH_M && len_d == ccc_pkg::LEN_TAG;
	endproperty
	a_mute: assert property (p_mute) else $error("mute not taken");
	property p_mute_keep;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		ex_go_q && ex_op_q == ccc_pkg::OP_SW |=> en_q == $past(en_q);
	endproperty
	a_mute_keep: assert property (p_mute_keep) else $error("switch changed mute");
	property p_unmute;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		ex_go_q && ex_op_q == ccc_pkg::OP_UNMUTE && !lock_q[oidx] |=> en_q[$past(oidx)];
	endproperty
	a_unmute: assert property (p_unmute) else $error("unmute not taken");
	property p_lock_hold;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		lock_q[0] && !pend_mask_q[0] |=> $stable(conn_q[0]) && (en_q[0] == $past(en_q[0]));
	endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("locked output changed");
	property p_unlock;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		ex_go_q && ex_op_q == ccc_pkg::OP_UNLOCK |=> !lock_q[$past(oidx)] && resp_d[1] == ccc_pkg::CH_ZERO;
	endproperty
	a_unlock: assert property (p_unlock) else $error("unlock not taken");
	property p_view_u;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		bld_go_q && ex_op_q == ccc_pkg::OP_VIEW && lock_q[0] && !en_q[0] |-> resp_d[5] == ccc_pkg::CH_U;
	endproperty
	a_view_u: assert property (p_view_u) else $error("view prefix wrong");
	property p_size;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		bld_go_q && ex_op_q == ccc_pkg::OP_SIZE |-> resp_d[7] == ccc_pkg::CH_XL && len_d == 5'h0C;
	endproperty
	a_size: assert property (p_size) else $error("size reply wrong");
	property p_batch_bound;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		timer_q < ccc_pkg::TMR_W'(BATCH_CYC);
	endproperty
	a_batch_bound: assert property (p_batch_bound) else $error("batch timer overran");
	property p_line_end;
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		tx_valid_q && tx_idx_q == tx_len_q && !$stable(tx_idx_q) |-> tx_data_q == ccc_pkg::CH_LF
			&& $past(tx_data_q) == ccc_pkg::CH_CR;
	endproperty
	a_line_end: assert property (p_line_end) else $error("line end not CR LF");
endmodule : ccc_core

/* File: design/ccc_pkg.sv */
// constants of the crosspoint command interpreter
// assumes one 25 MHz clock and a byte-wide character stream
//
// Contract
// - switch input to output, acknowledge output and input
// - output zero switches input to every unlocked output
// - switch acknowledgement carries no mute mark
// - mute disables output, replies mute-set tag
// - mute keeps connection; switching keeps output muted
// - unmute restores stored connection, replies cleared tag
// - lock freezes output state, replies lock-set tag
// - unlock always clears lock and replies
// - view query lists each output's input
// - view fields prefixed L locked, M muted, U both
// - size query replies inputs x outputs
// - fifth output is independent analog audio
// - switches under 10 ms apart apply together
// - batch only when no named output locked
// - otherwise switches apply one by one
// - interval measured on character arrival time
// - every reply ends with CR then LF
// - output numbers always two ASCII digits
package ccc_pkg;
	// ****************************************
	// crosspoint geometry
	// ****************************************
	localparam int NUM_IN = 8;
	localparam int NUM_OUT = 5;
	localparam int NUM_VID = 4;
	localparam int IN_W = 4;
	localparam int OUT_IW = 3;
	localparam int NUM_W = 7;
	localparam logic [IN_W-1:0] RST_CONN = 4'h1;
	localparam logic [NUM_W-1:0] DEC_BASE = 7'h0A;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ = 25_000_000;
	localparam int MS_HZ = 1000;
	localparam int BATCH_MS = 10;
	localparam int BATCH_CYC_DEF = CLK_HZ / MS_HZ * BATCH_MS;
	localparam int TMR_W = 18;
	// ****************************************
	// characters
	// ****************************************
	localparam logic [7:0] CH_LBRACE = 8'h7B;
	localparam logic [7:0] CH_RBRACE = 8'h7D;
	localparam logic [7:0] CH_AT = 8'h40;
	localparam logic [7:0] CH_HASH = 8'h23;
	localparam logic [7:0] CH_PLUS = 8'h2B;
	localparam logic [7:0] CH_GT = 8'h3E;
	localparam logic [7:0] CH_LT = 8'h3C;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_ONE = 8'h31;
	localparam logic [7:0] CH_NINE = 8'h39;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_LF = 8'h0A;
	localparam logic [7:0] CH_SP = 8'h20;
	localparam logic [7:0] CH_LPAR = 8'h28;
	localparam logic [7:0] CH_RPAR = 8'h29;
	localparam logic [7:0] CH_EQ = 8'h3D;
	localparam logic [7:0] CH_XL = 8'h78;
	localparam logic [7:0] CH_A = 8'h41;
	localparam logic [7:0] CH_E = 8'h45;
	localparam logic [7:0] CH_I = 8'h49;
	localparam logic [7:0] CH_L = 8'h4C;
	localparam logic [7:0] CH_M = 8'h4D;
	localparam logic [7:0] CH_O = 8'h4F;
	localparam logic [7:0] CH_R = 8'h52;
	localparam logic [7:0] CH_S = 8'h53;
	localparam logic [7:0] CH_T = 8'h54;
	localparam logic [7:0] CH_U = 8'h55;
	localparam logic [7:0] CH_V = 8'h56;
	localparam logic [7:0] CH_G = 8'h47;
	localparam logic [7:0] CH_Z = 8'h5A;
	localparam logic [7:0] CASE_MASK = 8'hDF;
	localparam logic [55:0] WORD_SIZE = 56'h4745545349_5A45;
	localparam logic [15:0] WORD_VIEW = 16'h5643;
	localparam logic [2:0] LEN_SIZE = 3'h7;
	localparam logic [2:0] LEN_VIEW = 3'h2;
	// ****************************************
	// reply buffer
	// ****************************************
	localparam int RESP_MAX = 28;
	localparam int LEN_W = 5;
	localparam logic [LEN_W-1:0] LEN_SWITCH = 5'h0B;
	localparam logic [LEN_W-1:0] LEN_TAG = 5'h09;
	// ****************************************
	// types
	// ****************************************
	typedef enum logic [3:0] {
		OP_NONE, OP_SW, OP_MUTE, OP_UNMUTE, OP_LOCK, OP_UNLOCK, OP_VIEW, OP_SIZE, OP_ERR
	} ccc_op_t;
	typedef enum logic {P_IDLE, P_BODY} ccc_pst_t;
endpackage : ccc_pkg

/* File: verification/ccc_host_model.sv */
// controller model: sends command bytes, takes reply bytes
// assumes the core's rx/tx valid-ready handshakes on one clock
`timescale 1ns/1ps
module ccc_host_model (
	// clock
	input wire logic clk_sys_in,
	// command characters
	output logic rx_valid_out,
	output logic [7:0] rx_data_out,
	input wire logic rx_ready_in,
	// reply characters
	input wire logic tx_valid_in,
	input wire logic [7:0] tx_data_in,
	output logic tx_ready_out
);
	int err;
	bit slow;
	initial begin
		rx_valid_out = 1'b0;
		rx_data_out = 8'h00;
		tx_ready_out = 1'b1;
		err = 0;
		slow = 1'b0;
	end
	// ****************************************
	// command bytes, held until taken
	// ****************************************
	task send(input string s);
		int i;
		int k;
		@(posedge clk_sys_in);
		#1;
		for (i = 0; i < s.len(); i++) begin
			rx_valid_out = 1'b1;
			rx_data_out = s[i];
			k = 0;
			do begin
				@(posedge clk_sys_in);
				k++;
			end while (rx_ready_in !== 1'b1 && k < 9999);
			if (k >= 9999) err++;
			#1;
		end
		rx_valid_out = 1'b0;
		rx_data_out = ~rx_data_out;
	endtask : send
	// ****************************************
	// one reply line up to LF, optional stalls
	// ****************************************
	task recv(output string r);
		int k;
		r = "";
		for (k = 0; k < 9999; k++) begin
			@(posedge clk_sys_in);
			if (tx_valid_in === 1'b1 && tx_ready_out === 1'b1) begin
				r = {r, string'(tx_data_in)};
				if (tx_data_in === 8'h0A) break;
			end
			#1;
			tx_ready_out = slow ? ~tx_ready_out : 1'b1;
		end
		if (k >= 9999) err++;
	endtask : recv
endmodule : ccc_host_model

/* File: verification/tb.sv */
// self-checking bench of the crosspoint command interpreter
// assumes ccc_core and the controller model; short batch window
`timescale 1ns/1ps
module tb;
	localparam int BC = 50;
	logic clk_sys_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic rx_valid, rx_ready, tx_valid, tx_ready;
	logic [7:0] rx_data, tx_data;
	logic [15:0] vid_sel;
	logic [3:0] vid_en, aud_sel;
	logic aud_en;
	logic [4:0] lock;
	int n_fail = 0;
	int num_checks = 0;
	always #20 clk_sys_in = ~clk_sys_in;
	ccc_core #(.BATCH_CYC(BC)) dut_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.rx_valid_in(rx_valid), .rx_data_in(rx_data), .rx_ready_out(rx_ready),
		.tx_valid_out(tx_valid), .tx_data_out(tx_data), .tx_ready_in(tx_ready),
		.vid_sel_out(vid_sel), .vid_en_out(vid_en), .aud_sel_out(aud_sel),
		.aud_en_out(aud_en), .lock_out(lock));
	ccc_host_model host_u (.clk_sys_in(clk_sys_in), .rx_valid_out(rx_valid), .rx_data_out(rx_data),
		.rx_ready_in(rx_ready), .tx_valid_in(tx_valid), .tx_data_in(tx_data), .tx_ready_out(tx_ready));
	// ****************************************
	// compare helpers
	// ****************************************
	task chkv(input string n, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chkv
	task cmd(input string c, input string e);
		string r;
		fork
			host_u.send(c);
			host_u.recv(r);
		join
		#1;
		num_checks++;
		if (r != e) begin
			n_fail++;
			$display("BAD %s expected %s seen %s", c, e, r);
		end
	endtask : cmd
	task settle;
		repeat (BC + 10) @(posedge clk_sys_in);
		#1;
	endtask : settle
	// ****************************************
	// scenarios
	// ****************************************
	task t_switch;
		cmd("{getsize}", "(SIZE=8x5)\r\n");
		cmd("{2@1}", "(O01 I02)\r\n");
		settle();
		chkv("sel1", 16'h0002, {12'h000, vid_sel[3:0]});
		cmd("{7@5}", "(O05 I07)\r\n");
		settle();
		chkv("aud", 16'h0171, {7'h00, aud_en, aud_sel, vid_sel[15:12]});
	endtask : t_switch
	task t_mute;
		cmd("{#01}", "(1MT01)\r\n");
		chkv("en", 16'h000E, {12'h000, vid_en});
		cmd("{VC}", "(ALL M02 01 01 01 07)\r\n");
		cmd("{3@1}", "(O01 I03)\r\n");
		settle();
		chkv("sel_en", 16'h003E, {8'h00, vid_sel[3:0], vid_en});
		cmd("{+01}", "(0MT01)\r\n");
		chkv("en", 16'h003F, {8'h00, vid_sel[3:0], vid_en});
	endtask : t_mute
	task t_lock;
		host_u.slow = 1'b1;
		cmd("{#>02}", "(1LO02)\r\n");
		cmd("{4@2}", "(O02 I04)\r\n");
		settle();
		chkv("sel2", 16'h1002, {vid_sel[7:4], 7'h00, lock});
		cmd("{#01}", "(1MT01)\r\n");
		cmd("{#>01}", "(1LO01)\r\n");
		cmd("{5@1}", "(O01 I05)\r\n");
		cmd("{vc}", "(ALL U03 L01 01 01 07)\r\n");
		cmd("{+<02}", "(0LO02)\r\n");
		cmd("{+<02}", "(0LO02)\r\n");
		cmd("{+<01}", "(0LO01)\r\n");
		cmd("{+01}", "(0MT01)\r\n");
		cmd("{VC}", "(ALL 03 01 01 01 07)\r\n");
		host_u.slow = 1'b0;
	endtask : t_lock
	task t_batch;
		string a, b;
		int k;
		cmd("{5@0}", "(I05 ALL)\r\n");
		chkv("all", 16'h5555, vid_sel);
		fork
			host_u.send("{2@3}{6@4}");
			begin
				host_u.recv(a);
				host_u.recv(b);
			end
		join
		#1;
		chkv("acks", 16'h0001, {15'h0000, a == "(O03 I02)\r\n" && b == "(O04 I06)\r\n"});
		chkv("pend", 16'h5555, vid_sel);
		for (k = 0; k < 200 && vid_sel[11:8] === 4'h5; k++) begin
			@(posedge clk_sys_in);
			#1;
		end
		chkv("batch", 16'h6255, vid_sel);
	endtask : t_batch
	// ****************************************
	// verdict
	// ****************************************
	task summarize;
		n_fail += host_u.err;
		if (n_fail == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize
	initial begin
		repeat (8) @(posedge clk_sys_in);
		#1;
		rst_n_in = 1'b1;
		chkv("rst", 16'h111F, {vid_sel[15:4], vid_en});
		t_switch();
		t_mute();
		t_lock();
		t_batch();
		summarize();
	end
endmodule : tb
